/* File: scsf_pkg.sv */
// constants for the smart card serial status flag block
package scsf_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] SCSF_STATUS_OFS = 8'h00;
	localparam logic [7:0] SCSF_CONTROL_OFS = 8'h04;
	localparam logic [7:0] SCSF_TXBUF_OFS = 8'h08;
	localparam logic [7:0] SCSF_RXBUF_OFS = 8'h0c;
	// ----------------------------------------
	// status field positions and reset
	// ----------------------------------------
	localparam int SCSF_TX_EMPTY_BIT = 7;
	localparam int SCSF_RX_FULL_BIT = 6;
	localparam int SCSF_OVERRUN_BIT = 5;
	localparam int SCSF_ERR_SIG_BIT = 4;
	localparam int SCSF_FLAG_LO = 4;
	// flag vector order: tx empty, rx full, overrun, error signal
	localparam int SCSF_F_TX = 3;
	localparam int SCSF_F_RX = 2;
	localparam int SCSF_F_OVR = 1;
	localparam int SCSF_F_ESIG = 0;
	localparam logic [3:0] SCSF_FLAGS_RST = 4'h8;
	localparam logic [3:0] SCSF_ARMED_RST = 4'h0;
	localparam logic SCSF_BIT_RST = 1'h0;
	// ----------------------------------------
	// control field positions and reset
	// ----------------------------------------
	localparam int SCSF_TX_EN_BIT = 5;
	localparam int SCSF_RX_EN_BIT = 4;
	localparam int SCSF_SYNC_BIT = 0;
	localparam logic SCSF_TX_EN_RST = 1'h0;
	localparam logic SCSF_RX_EN_RST = 1'h0;
	localparam logic SCSF_SYNC_RST = 1'h0;
	localparam logic [7:0] SCSF_BYTE_RST = 8'h00;
	localparam logic [31:0] SCSF_WORD_RST = 32'h0000_0000;
	// ----------------------------------------
	// bus encodings
	// ----------------------------------------
	localparam logic [1:0] SCSF_HTRANS_NONSEQ = 2'h2;
	localparam logic SCSF_HRESP_OKAY = 1'h0;
endpackage

/* File: scsf_status.sv */
// smart card serial status flags with ahb-lite register slave
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module scsf_status
	import scsf_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// dma side
	output logic tx_empty_interrupt,
	output logic rx_full_interrupt,
	input wire logic dma_tx_wr,
	input wire logic [7:0] dma_tx_data,
	input wire logic dma_rx_rd,
	output logic [7:0] dma_rx_data,
	// serial engine side
	output logic tx_start,
	output logic [7:0] tx_shift_register,
	input wire logic tx_done,
	input wire logic error_signal_low,
	output logic rx_enable,
	input wire logic rx_done,
	input wire logic [7:0] rx_byte
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] flags;
		logic [3:0] armed;
		logic tx_en;
		logic rx_en;
		logic sync;
		logic [7:0] tx_buffer;
		logic [7:0] tx_shift;
		logic tx_busy;
		logic tx_start;
		logic [7:0] rx_buffer;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} scsf_state_t;

	scsf_state_t st;
	scsf_state_t next_st;

	logic take;
	logic xfer;
	logic rx_ok;
	logic [3:0] set_f;
	logic [3:0] clr_f;
	logic [3:0] clr_sw;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.tx_start = 1'b0;
		set_f = 4'h0;
		clr_f = 4'h0;
		clr_sw = 4'h0;
		take = hsel && hready && (htrans == SCSF_HTRANS_NONSEQ);
		// address phase: capture, prepare read data one cycle early
		next_st.wr_pend = take && hwrite;
		if (take) begin
			next_st.wr_addr = haddr;
		end
		if (take && !hwrite) begin
			next_st.rdata = SCSF_WORD_RST;
			case (haddr)
				SCSF_STATUS_OFS: begin
					next_st.rdata[SCSF_TX_EMPTY_BIT:SCSF_FLAG_LO] = st.flags;
					// reading a 1 arms that flag for one clear
					next_st.armed = st.armed | st.flags;
				end
				SCSF_CONTROL_OFS: begin
					next_st.rdata[SCSF_TX_EN_BIT] = st.tx_en;
					next_st.rdata[SCSF_RX_EN_BIT] = st.rx_en;
					next_st.rdata[SCSF_SYNC_BIT] = st.sync;
				end
				SCSF_TXBUF_OFS: next_st.rdata[7:0] = st.tx_buffer;
				SCSF_RXBUF_OFS: next_st.rdata[7:0] = st.rx_buffer;
				default: next_st.rdata = SCSF_WORD_RST;
			endcase
		end
		// data phase of a write
		if (st.wr_pend) begin
			case (st.wr_addr)
				SCSF_STATUS_OFS: begin
					// only a 0 clears; a 1 leaves the flag alone
					clr_sw = st.armed & ~hwdata[SCSF_TX_EMPTY_BIT:SCSF_FLAG_LO];
					next_st.armed = next_st.armed & ~clr_sw;
				end
				SCSF_CONTROL_OFS: begin
					next_st.tx_en = hwdata[SCSF_TX_EN_BIT];
					// receiver disable touches no flag
					next_st.rx_en = hwdata[SCSF_RX_EN_BIT];
					next_st.sync = hwdata[SCSF_SYNC_BIT];
				end
				SCSF_TXBUF_OFS: next_st.tx_buffer = hwdata[7:0];
				default: next_st.tx_en = st.tx_en;
			endcase
		end
		clr_f = clr_sw;
		// software clear of tx empty, rx full, overrun and error signal
		// dma transmit write
		if (dma_tx_wr) begin
			next_st.tx_buffer = dma_tx_data;
			clr_f[SCSF_F_TX] = 1'b1;
		end
		// dma receive read
		if (dma_rx_rd) begin
			clr_f[SCSF_F_RX] = 1'b1;
		end
		// transmitter disabled holds tx empty set
		if (!st.tx_en) begin
			set_f[SCSF_F_TX] = 1'b1;
		end
		// buffer to shift register; overrun halts it in synchronous mode
		xfer = st.tx_en && !st.flags[SCSF_F_TX] && !st.tx_busy && !(st.sync && st.flags[SCSF_F_OVR]);
		if (tx_done) begin
			next_st.tx_busy = 1'b0;
		end
		if (xfer) begin
			next_st.tx_shift = st.tx_buffer;
			next_st.tx_busy = 1'b1;
			next_st.tx_start = 1'b1;
			set_f[SCSF_F_TX] = 1'b1;
		end
		// low error signal sampled while a byte is out
		if (error_signal_low && st.tx_busy) begin
			set_f[SCSF_F_ESIG] = 1'b1;
		end
		// reception completes only while enabled and no overrun stands
		rx_ok = rx_done && st.rx_en && !st.flags[SCSF_F_OVR];
		if (rx_ok) begin
			// a same-cycle dma read drains the buffer, so no overrun
			if (st.flags[SCSF_F_RX] && !dma_rx_rd) begin
				set_f[SCSF_F_OVR] = 1'b1;
				// old byte kept, new one dropped
				next_st.rx_buffer = st.rx_buffer;
			end else begin
				next_st.rx_buffer = rx_byte;
				set_f[SCSF_F_RX] = 1'b1;
			end
		end
		// set beats clear so no event is lost
		next_st.flags = (st.flags & ~clr_f) | set_f;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st.flags <= SCSF_FLAGS_RST;
			st.armed <= SCSF_ARMED_RST;
			st.tx_en <= SCSF_TX_EN_RST;
			st.rx_en <= SCSF_RX_EN_RST;
			st.sync <= SCSF_SYNC_RST;
			st.tx_buffer <= SCSF_BYTE_RST;
			st.tx_shift <= SCSF_BYTE_RST;
			st.tx_busy <= SCSF_BIT_RST;
			st.tx_start <= SCSF_BIT_RST;
			st.rx_buffer <= SCSF_BYTE_RST;
			st.wr_pend <= SCSF_BIT_RST;
			st.wr_addr <= SCSF_BYTE_RST;
			st.rdata <= SCSF_WORD_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata = st.rdata;
	assign hreadyout = 1'b1;
	assign hresp = SCSF_HRESP_OKAY;
	assign tx_empty_interrupt = st.tx_en && st.flags[SCSF_F_TX];
	assign rx_full_interrupt = st.flags[SCSF_F_RX];
	assign dma_rx_data = st.rx_buffer;
	assign tx_start = st.tx_start;
	assign tx_shift_register = st.tx_shift;
	assign rx_enable = st.rx_en && !st.flags[SCSF_F_OVR];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic wr_status;
	logic rd_status;
	assign wr_status = st.wr_pend && (st.wr_addr == SCSF_STATUS_OFS);
	assign rd_status = take && !hwrite && (haddr == SCSF_STATUS_OFS);

	// transmit side
	AST_TX_EMPTY_OFF: assert property (!st.tx_en |=> st.flags[SCSF_F_TX])
		else $error("tx empty flag low while transmitter disabled");

	AST_TX_EMPTY_ON_LOAD: assert property (st.tx_start |-> st.flags[SCSF_F_TX] && st.tx_busy)
		else $error("tx empty flag not set after shift register load");

	// a load in the same cycle sets the flag again, so it is left out
	AST_TX_EMPTY_SW_CLR: assert property (wr_status && st.armed[SCSF_F_TX] && !hwdata[SCSF_TX_EMPTY_BIT]
		&& st.tx_en && !xfer |=> !st.flags[SCSF_F_TX])
		else $error("tx empty flag not cleared by software");

	AST_TX_EMPTY_DMA_CLR: assert property (dma_tx_wr && st.tx_en && st.flags[SCSF_F_TX]
		|=> !st.flags[SCSF_F_TX] && st.tx_buffer == $past(dma_tx_data))
		else $error("tx empty flag not cleared by dma write");

	AST_SHIFT_LOAD: assert property (st.tx_start |-> st.tx_shift == $past(st.tx_buffer))
		else $error("shift register not loaded from tx buffer");

	AST_START_PULSE: assert property (st.tx_start |=> !st.tx_start)
		else $error("tx start longer than one cycle");

	AST_NO_LOAD_BUSY: assert property (st.tx_busy |=> !st.tx_start)
		else $error("shift register reloaded while busy");

	AST_TX_IRQ_OFF: assert property (!st.tx_en |-> !tx_empty_interrupt)
		else $error("tx request raised while transmitter disabled");

	// receive side
	AST_RX_FULL_SET: assert property (rx_done && st.rx_en && !st.flags[SCSF_F_OVR] && !st.flags[SCSF_F_RX]
		|=> st.flags[SCSF_F_RX] && st.rx_buffer == $past(rx_byte))
		else $error("rx full flag or buffer wrong after reception");

	AST_RX_FULL_SW_CLR: assert property (wr_status && st.armed[SCSF_F_RX] && !hwdata[SCSF_RX_FULL_BIT] && !rx_done
		|=> !st.flags[SCSF_F_RX])
		else $error("rx full flag not cleared by software");

	AST_RX_FULL_DMA_CLR: assert property (dma_rx_rd && !rx_done |=> !st.flags[SCSF_F_RX])
		else $error("rx full flag not cleared by dma read");

	AST_RX_OFF_HOLDS: assert property (!st.rx_en && !dma_rx_rd && !st.wr_pend
		|=> st.flags[SCSF_F_RX:SCSF_F_OVR] == $past(st.flags[SCSF_F_RX:SCSF_F_OVR]))
		else $error("flags changed while receiver disabled");

	AST_RX_OFF_GATE: assert property (!st.rx_en |-> !rx_enable)
		else $error("receiver enabled while disabled by software");

	// dma drain in the same cycle leaves room for the new byte
	AST_RX_DRAIN_SAME: assert property (rx_done && st.rx_en && !st.flags[SCSF_F_OVR] && st.flags[SCSF_F_RX]
		&& dma_rx_rd |=> st.flags[SCSF_F_RX] && st.rx_buffer == $past(rx_byte))
		else $error("same cycle drain lost the new byte");

	// overrun
	AST_OVERRUN: assert property (rx_done && st.rx_en && !st.flags[SCSF_F_OVR] && st.flags[SCSF_F_RX] && !dma_rx_rd
		|=> st.flags[SCSF_F_OVR] && st.rx_buffer == $past(st.rx_buffer))
		else $error("overrun not flagged or old byte lost");

	AST_OVR_DROPS: assert property (rx_done && st.flags[SCSF_F_OVR] |=> st.rx_buffer == $past(st.rx_buffer))
		else $error("byte stored during overrun");

	AST_OVR_BLOCKS: assert property (st.flags[SCSF_F_OVR] && st.sync |-> !rx_enable ##1 !st.tx_start)
		else $error("activity continued during overrun");

	AST_OVR_SW_CLR: assert property (wr_status && st.armed[SCSF_F_OVR] && !hwdata[SCSF_OVERRUN_BIT] && !rx_done
		|=> !st.flags[SCSF_F_OVR])
		else $error("overrun flag not cleared by software");

	// error signal
	AST_ESIG_SET: assert property (error_signal_low && st.tx_busy |=> st.flags[SCSF_F_ESIG])
		else $error("error signal flag not set");

	AST_ESIG_SW_CLR: assert property (wr_status && st.armed[SCSF_F_ESIG] && !hwdata[SCSF_ERR_SIG_BIT]
		&& !(error_signal_low && st.tx_busy) |=> !st.flags[SCSF_F_ESIG])
		else $error("error signal flag not cleared by software");

	// arming and clearing by software
	AST_UNARMED_KEEPS: assert property (wr_status && st.armed == 4'h0 && !dma_rx_rd
		|=> (st.flags[SCSF_F_RX:SCSF_F_ESIG] | ~$past(st.flags[SCSF_F_RX:SCSF_F_ESIG])) == 3'h7)
		else $error("flag cleared without a prior read");

	AST_ONES_KEEP: assert property (wr_status && hwdata[SCSF_TX_EMPTY_BIT:SCSF_FLAG_LO] == 4'hf && !dma_rx_rd
		&& !dma_tx_wr |=> (st.flags | ~$past(st.flags)) == 4'hf)
		else $error("writing ones cleared a flag");

	AST_ARM_ON_READ: assert property (rd_status && !st.wr_pend
		|=> (st.armed & $past(st.flags)) == $past(st.flags))
		else $error("read of a set flag did not arm it");

	AST_ARM_SPENT: assert property (wr_status && clr_sw != 4'h0 && !rd_status
		|=> (st.armed & $past(clr_sw)) == 4'h0)
		else $error("arm not consumed by its clear");

	AST_STATUS_READ: assert property (rd_status
		|=> hrdata == {24'h00_0000, $past(st.flags), 4'h0})
		else $error("status read shows wrong flags");

	AST_SET_WINS: assert property (wr_status && st.armed[SCSF_F_ESIG] && !hwdata[SCSF_ERR_SIG_BIT]
		&& error_signal_low && st.tx_busy |=> st.flags[SCSF_F_ESIG])
		else $error("clear beat a coincident set");

	// bus answer and reset values
	AST_BUS_ZERO_WAIT: assert property (hreadyout && hresp == SCSF_HRESP_OKAY)
		else $error("bus slave stalled or errored");

	AST_RESET_FLAGS: assert property ($fell(rst) |-> st.flags == SCSF_FLAGS_RST)
		else $error("flags wrong after reset");

	COV_OVERRUN: cover property (st.flags[SCSF_F_RX] ##1 st.flags[SCSF_F_OVR]);
	COV_SW_CLEAR: cover property (wr_status && clr_sw != 4'h0);
	COV_TX_LOAD: cover property (dma_tx_wr ##[1:4] st.tx_start);
	COV_ESIG: cover property (error_signal_low && st.tx_busy);
	COV_SYNC_HOLD: cover property (st.sync && st.flags[SCSF_F_OVR] && !st.flags[SCSF_F_TX]);

endmodule

/* File: scsf_engine_model.sv */
// behavioural serial engine standing on the line side of the status block
`timescale 1ns/1ps
module scsf_engine_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// commands from the bench
	input wire logic err_mode,
	input wire logic rx_go,
	input wire logic [7:0] rx_val,
	// status block side
	input wire logic tx_start,
	input wire logic rx_enable,
	output logic tx_done,
	output logic error_signal_low,
	output logic rx_done,
	output logic [7:0] rx_byte
);
	logic [4:0] busy_cnt;
	// card pulls the line low midway through a character when told to
	assign error_signal_low = err_mode && (busy_cnt == 5'h0a);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_cnt <= 5'h00;
			tx_done <= 1'b0;
			rx_done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			tx_done <= 1'b0;
			rx_done <= 1'b0;
			if (tx_start) begin
				busy_cnt <= 5'h14;
			end else if (busy_cnt != 5'h00) begin
				busy_cnt <= busy_cnt - 5'h01;
				tx_done <= (busy_cnt == 5'h01);
			end
			// no frame while receiver is off; byte toggles outside frames
			if (rx_go && rx_enable) begin
				rx_done <= 1'b1;
				rx_byte <= rx_val;
			end else begin
				rx_byte <= ~rx_byte;
			end
		end
	end
endmodule

/* File: smartcard_serial_status_flags_bench.sv */
// self-checking bench for the smart card serial status flags
`timescale 1ns/1ps
module smartcard_serial_status_flags_bench;
	import scsf_pkg::*;
	logic mclk, rst, hsel, hwrite, dma_tx_wr, dma_rx_rd, err_mode, rx_go;
	logic hreadyout, hresp, tx_empty_interrupt, rx_full_interrupt, tx_start, tx_done, error_signal_low;
	logic rx_enable, rx_done;
	logic [7:0] haddr, dma_tx_data, rx_val, tx_shift_register, dma_rx_data, rx_byte, last_tx;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	int failures = 0;
	int n_checks = 0;
	int n_tx = 0;
	scsf_status i_scsf_status (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_empty_interrupt(tx_empty_interrupt),
		.rx_full_interrupt(rx_full_interrupt), .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data),
		.dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data), .tx_start(tx_start),
		.tx_shift_register(tx_shift_register), .tx_done(tx_done), .error_signal_low(error_signal_low),
		.rx_enable(rx_enable), .rx_done(rx_done), .rx_byte(rx_byte));
	scsf_engine_model i_scsf_engine_model (.mclk(mclk), .rst(rst), .err_mode(err_mode), .rx_go(rx_go),
		.rx_val(rx_val), .tx_start(tx_start), .rx_enable(rx_enable), .tx_done(tx_done),
		.error_signal_low(error_signal_low), .rx_done(rx_done), .rx_byte(rx_byte));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (tx_start === 1'b1) begin
			last_tx <= tx_shift_register;
			n_tx <= n_tx + 1;
		end
	end
	task automatic complete_run();
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// master holds each phase until hready seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= SCSF_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic stat(input logic [31:0] exp);
		bus(1'b0, SCSF_STATUS_OFS, 32'h0);
		chk("status", q, exp);
	endtask
	task automatic rx(input logic [7:0] b);
		@(posedge mclk);
		rx_val <= b;
		rx_go <= 1'b1;
		@(posedge mclk);
		rx_go <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic pulse_dma(input logic wr);
		@(posedge mclk);
		dma_tx_wr <= wr;
		dma_rx_rd <= !wr;
		@(posedge mclk);
		dma_tx_wr <= 1'b0;
		dma_rx_rd <= 1'b0;
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 200 && n_tx < n; i++) @(posedge mclk);
		chk("tx loads", n_tx, n);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_receive();
		bus(1'b1, SCSF_CONTROL_OFS, 32'h10);
		rx(8'h3c);
		bus(1'b1, SCSF_STATUS_OFS, 32'h0); // zero write, rx full unarmed
		stat(32'hc0);
		chk("rx data", dma_rx_data, 8'h3c);
		bus(1'b1, SCSF_CONTROL_OFS, 32'h00);
		stat(32'hc0);
		bus(1'b1, SCSF_CONTROL_OFS, 32'h10);
		rx(8'h99);
		stat(32'he0);
		chk("rx kept", dma_rx_data, 8'h3c);
		chk("rx halted", rx_enable, 1'b0);
		bus(1'b1, SCSF_STATUS_OFS, 32'hc0);
		stat(32'hc0);
		chk("rx resumed", rx_enable, 1'b1);
		bus(1'b1, SCSF_STATUS_OFS, 32'h80);
		stat(32'h80);
		rx(8'h11);
		chk("rx new", dma_rx_data, 8'h11);
		pulse_dma(1'b0);
		stat(32'h80);
		chk("rx irq low", rx_full_interrupt, 1'b0);
	endtask
	task automatic t_sync();
		bus(1'b1, SCSF_CONTROL_OFS, 32'h31);
		rx(8'h21);
		rx(8'h42);
		chk("rx irq", rx_full_interrupt, 1'b1);
		stat(32'he0);
		bus(1'b1, SCSF_TXBUF_OFS, 32'h77);
		bus(1'b1, SCSF_STATUS_OFS, 32'h60);
		repeat (10) @(posedge mclk);
		chk("tx held", n_tx, 2);
		stat(32'h60);
		bus(1'b1, SCSF_STATUS_OFS, 32'hc0);
		wait_tx(3);
		chk("sync byte", last_tx, 8'h77);
		stat(32'hc0);
		bus(1'b0, SCSF_CONTROL_OFS, 32'h0);
		chk("control", q, 32'h31);
		bus(1'b0, SCSF_RXBUF_OFS, 32'h0);
		chk("rx buffer", q, 32'h21);
		chk("hresp", hresp, SCSF_HRESP_OKAY);
	endtask
	task automatic t_transmit();
		bus(1'b1, SCSF_CONTROL_OFS, 32'h20);
		bus(1'b1, SCSF_TXBUF_OFS, 32'h5a);
		stat(32'h80);
		bus(1'b1, SCSF_STATUS_OFS, 32'h0);
		wait_tx(1);
		chk("tx byte", last_tx, 8'h5a);
		stat(32'h80);
		chk("tx irq", tx_empty_interrupt, 1'b1);
		dma_tx_data <= 8'ha5;
		err_mode <= 1'b1;
		pulse_dma(1'b1);
		stat(32'h00);
		wait_tx(2);
		chk("dma byte", last_tx, 8'ha5);
		repeat (25) @(posedge mclk);
		err_mode <= 1'b0;
		stat(32'h90);
		bus(1'b1, SCSF_STATUS_OFS, 32'he0);
		stat(32'h80);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{hsel, hwrite, dma_tx_wr, dma_rx_rd, err_mode, rx_go} = 6'h00;
		{haddr, dma_tx_data, rx_val} = 24'h000000;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		stat(32'h80);
		t_receive();
		t_transmit();
		t_sync();
		complete_run();
	end
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		complete_run();
	end
endmodule
